// File: verilog/oag_addr_gen.sv
/*
 Operand effective-address generator: takes a decoded request and the
 pointer registers, answers one cycle later with a logical address, its
 space, the access size and whether it is a program-counter load.
 Assumes decode holds req_valid for one cycle per request and that memory
 management translation, when enabled, sits downstream of addr.
*/
// How it works
// RL1: Direct mode: instruction address, I/O or data
// RL2: Direct jump or call loads address into counter
// RL3: Table mode adds field to selected register
// RL4: Table mode operands live in data memory
// RL5: Short mode sign-extends byte, adds index register
// RL6: Short mode operands live in data memory
// RL7: Counter mode adds displacement to next address
// RL8: Extended instructions use template address as base
// RL9: Counter mode operands live in program memory
// RL10: Counter mode control transfers load the sum
// RL11: Stack mode adds word displacement to pointer
// RL12: User/system bit picks the stack pointer
// RL13: Pair mode sums two pointer registers, data space
// RL14: Addresses count bytes, the smallest unit
// RL15: I/O accesses may be byte or word
// RL16: Bit number is a byte-local index
// RL17: Decimal digits packed two per byte
// RL18: Block lengths up to the maximum byte count
// RL19: Block I/O moves bytes or words
// RL20: Extended transfers hold at most sixteen bytes
// RL21: Output is logical; translation happens downstream
// RL22: Sums wrap at sixteen bits
`default_nettype none
`include "oag_regs.svh"
module oag_addr_gen
   import oag_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic req_valid,
   input wire oag_req_t req,
   input wire oag_regs_t regs,
   input wire logic [16:0] block_len,
   input wire logic [4:0] ext_len,
   input wire logic [2:0] bit_num,
   input wire logic [7:0] bcd_byte,
   output logic ans_valid,
   output oag_ans_t ans,
   output logic len_ok,
   output logic [7:0] bit_mask,
   output logic [3:0] bcd_hi,
   output logic [3:0] bcd_lo
);
   logic valid_ff, nxt_valid;
   oag_ans_t ans_ff, nxt_ans;
   logic len_ok_ff, nxt_len_ok;
   logic [7:0] mask_ff, nxt_mask;
   logic [7:0] bcd_ff, nxt_bcd;
   logic [15:0] sel_base, sel_add, sext8, pc_base, pc_disp, stk;

   function automatic logic [15:0] pick(input logic [1:0] s, input oag_regs_t r);
      logic [15:0] v;
      v = r.primary_pointer_pair;
      if (s == `OAG_SEL_INDEX_ONE)
      begin
         v = r.index_register_one;
      end
      else if (s == `OAG_SEL_INDEX_TWO)
      begin
         v = r.index_register_two;
      end
      return v;
   endfunction

   always_comb
   begin
      sel_base = pick(req.base_sel, regs);
      sel_add = pick(req.add_sel, regs);
      sext8 = {{8{req.disp[`OAG_SIGN_BIT]}}, req.disp[7:0]}; // [RL5]
      pc_base = req.is_ext ? regs.template_pc : regs.next_pc; // [RL7] [RL8]
      pc_disp = req.word_disp ? req.disp : sext8; // [RL7]
      stk = regs.user_mode ? regs.usr_sp : regs.sys_sp; // [RL12]
      nxt_valid = valid_ff;
      nxt_ans = ans_ff;
      nxt_len_ok = len_ok_ff;
      nxt_mask = mask_ff;
      nxt_bcd = bcd_ff;
      if (req_valid)
      begin
         nxt_valid = 1'b1;
         nxt_ans.word_size = req.word_size; // [RL15] [RL19]
         nxt_ans.load_pc = 1'b0;
         nxt_ans.space = OAG_SP_DATA;
         // Address is logical and byte granular; 16-bit sums drop the carry
         unique case (req.mode)
            OAG_DIRECT:
            begin
               nxt_ans.addr = req.addr_field; // [RL1] [RL14] [RL21]
               nxt_ans.space = req.is_io ? OAG_SP_IO : OAG_SP_DATA; // [RL1]
               nxt_ans.load_pc = req.is_jump; // [RL2]
            end
            OAG_TABLE:
            begin
               nxt_ans.addr = 16'(req.addr_field + sel_base); // [RL3] [RL22]
               nxt_ans.space = OAG_SP_DATA; // [RL4]
            end
            OAG_SHORT:
            begin
               // Primary pair is not a legal base here; it falls to index one
               nxt_ans.addr = 16'(((req.base_sel == `OAG_SEL_INDEX_TWO) ?
                  regs.index_register_two : regs.index_register_one) + sext8); // [RL5]
               nxt_ans.space = OAG_SP_DATA; // [RL6]
            end
            OAG_COUNTER:
            begin
               nxt_ans.addr = 16'(pc_base + pc_disp); // [RL7] [RL22]
               nxt_ans.space = OAG_SP_PROG; // [RL9]
               nxt_ans.load_pc = req.is_jump; // [RL10]
            end
            OAG_STACK:
            begin
               nxt_ans.addr = 16'(stk + req.disp); // [RL11] [RL22]
               nxt_ans.space = OAG_SP_DATA; // [RL11]
            end
            OAG_PAIR:
            begin
               nxt_ans.addr = 16'(sel_base + sel_add); // [RL13] [RL22]
               nxt_ans.space = OAG_SP_DATA; // [RL13]
            end
            default:
            begin
               nxt_ans.addr = req.addr_field;
            end
         endcase
      end
      else
      begin
         nxt_valid = 1'b0;
      end
      nxt_len_ok = (block_len != 17'h00000) && (block_len <= `OAG_BLOCK_MAX_LEN) &&
         (ext_len <= `OAG_EXT_MAX_LEN); // [RL18] [RL20]
      nxt_mask = 8'(8'h01 << bit_num); // [RL16]
      nxt_bcd = bcd_byte; // [RL17]
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         valid_ff <= 1'b0;
         ans_ff <= '0;
         len_ok_ff <= 1'b0;
         mask_ff <= 8'h00;
         bcd_ff <= 8'h00;
      end
      else if (ce)
      begin
         valid_ff <= nxt_valid;
         ans_ff <= nxt_ans;
         len_ok_ff <= nxt_len_ok;
         mask_ff <= nxt_mask;
         bcd_ff <= nxt_bcd;
      end
   end

   assign ans_valid = valid_ff;
   assign ans = ans_ff;
   assign len_ok = len_ok_ff;
   assign bit_mask = mask_ff;
   assign bcd_hi = bcd_ff[7:4];
   assign bcd_lo = bcd_ff[3:0];

   sequence s_req(oag_mode_t m);
      ce && req_valid && req.mode == m;
   endsequence

   a_direct_space: assert property (@(posedge clk) disable iff (srst)
      s_req(OAG_DIRECT) |=> ans.addr == $past(req.addr_field) &&
      ans.space == ($past(req.is_io) ? OAG_SP_IO : OAG_SP_DATA)) // [RL1]
      else $error("direct address or space wrong");
   a_direct_jump: assert property (@(posedge clk) disable iff (srst)
      s_req(OAG_DIRECT) |=> ans.load_pc == $past(req.is_jump)) // [RL2]
      else $error("direct jump load wrong");
   a_table_sum: assert property (@(posedge clk) disable iff (srst)
      s_req(OAG_TABLE) |=> ans.space == OAG_SP_DATA &&
      ans.addr == 16'($past(req.addr_field) + $past(sel_base))) // [RL3]
      else $error("table sum wrong");
   a_short_sext: assert property (@(posedge clk) disable iff (srst)
      s_req(OAG_SHORT) && req.base_sel == `OAG_SEL_INDEX_ONE |=>
      ans.addr == 16'($past(regs.index_register_one) +
      {{8{$past(req.disp[7])}}, $past(req.disp[7:0])}) && ans.space == OAG_SP_DATA) // [RL5]
      else $error("short displacement wrong");
   a_counter_base: assert property (@(posedge clk) disable iff (srst)
      s_req(OAG_COUNTER) && req.is_ext && req.word_disp |=>
      ans.addr == 16'($past(regs.template_pc) + $past(req.disp))) // [RL8]
      else $error("template base wrong");
   a_counter_space: assert property (@(posedge clk) disable iff (srst)
      s_req(OAG_COUNTER) |=> ans.space == OAG_SP_PROG &&
      ans.load_pc == $past(req.is_jump)) // [RL9]
      else $error("counter relative space wrong");
   a_stack_pick: assert property (@(posedge clk) disable iff (srst)
      s_req(OAG_STACK) |=> ans.addr == 16'(($past(regs.user_mode) ?
      $past(regs.usr_sp) : $past(regs.sys_sp)) + $past(req.disp))) // [RL12]
      else $error("stack pointer choice wrong");
   a_pair_sum: assert property (@(posedge clk) disable iff (srst)
      s_req(OAG_PAIR) |=> ans.addr == 16'($past(sel_base) + $past(sel_add)) &&
      ans.space == OAG_SP_DATA) // [RL13]
      else $error("pair sum wrong");
   a_valid_pulse: assert property (@(posedge clk) disable iff (srst)
      ce && !req_valid |=> !ans_valid) // [RL15]
      else $error("answer without request");

   sequence s_any_req;
      ce && req_valid;
   endsequence

   sequence s_byte_disp;
      {{8{$past(req.disp[7])}}, $past(req.disp[7:0])};
   endsequence

   // Table, short, stack and pair modes never redirect the program counter

   a_table_space: assert property (@(posedge clk) disable iff (srst) // [RL4]
      s_req(OAG_TABLE) |=>
      ans.space == OAG_SP_DATA && !ans.load_pc)
      else $error("table operand not in data space");

   a_short_space: assert property (@(posedge clk) disable iff (srst) // [RL6]
      s_req(OAG_SHORT) |=>
      ans.space == OAG_SP_DATA && !ans.load_pc)
      else $error("short operand not in data space");

   a_short_two: assert property (@(posedge clk) disable iff (srst) // [RL5]
      s_req(OAG_SHORT) && req.base_sel == `OAG_SEL_INDEX_TWO |=>
      ans.addr == 16'($past(regs.index_register_two) + {{8{$past(req.disp[7])}}, $past(req.disp[7:0])}))
      else $error("short displacement on index two wrong");

   a_counter_next: assert property (@(posedge clk) disable iff (srst) // [RL7]
      s_req(OAG_COUNTER) && !req.is_ext && req.word_disp |=>
      ans.addr == 16'($past(regs.next_pc) + $past(req.disp)))
      else $error("word relative sum wrong");

   a_counter_byte: assert property (@(posedge clk) disable iff (srst) // [RL7]
      s_req(OAG_COUNTER) && !req.is_ext && !req.word_disp |=>
      ans.addr == 16'($past(regs.next_pc) + {{8{$past(req.disp[7])}}, $past(req.disp[7:0])}))
      else $error("byte relative sum wrong");

   a_counter_jump: assert property (@(posedge clk) disable iff (srst) // [RL10]
      s_req(OAG_COUNTER) && req.is_jump |=>
      ans.load_pc)
      else $error("relative jump does not load counter");

   a_stack_space: assert property (@(posedge clk) disable iff (srst) // [RL11]
      s_req(OAG_STACK) |=>
      ans.space == OAG_SP_DATA && !ans.load_pc)
      else $error("stack operand not in data space");

   a_pair_nojump: assert property (@(posedge clk) disable iff (srst) // [RL13]
      s_req(OAG_PAIR) |=>
      !ans.load_pc)
      else $error("pair sum loads counter");

   a_size_follow: assert property (@(posedge clk) disable iff (srst) // [RL15]
      s_any_req |=>
      ans.word_size == $past(req.word_size))
      else $error("access size lost");

   a_valid_answer: assert property (@(posedge clk) disable iff (srst) // [RL21]
      s_any_req |=>
      ans_valid)
      else $error("request without answer");

   // Side outputs follow their inputs one enabled cycle later

   a_bit_mask: assert property (@(posedge clk) disable iff (srst) // [RL16]
      ce |=>
      $onehot(bit_mask) && bit_mask[$past(bit_num)])
      else $error("bit mask wrong");

   a_bcd_split: assert property (@(posedge clk) disable iff (srst) // [RL17]
      ce |=>
      {bcd_hi, bcd_lo} == $past(bcd_byte))
      else $error("digit split wrong");

   a_len_limit: assert property (@(posedge clk) disable iff (srst) // [RL18]
      ce && (block_len > `OAG_BLOCK_MAX_LEN || block_len == 17'h00000) |=>
      !len_ok)
      else $error("block length accepted out of range");

   a_ext_limit: assert property (@(posedge clk) disable iff (srst) // [RL20]
      ce && ext_len > `OAG_EXT_MAX_LEN |=>
      !len_ok)
      else $error("extended length accepted out of range");

   a_len_good: assert property (@(posedge clk) disable iff (srst) // [RL18] [RL20]
      ce && block_len != 17'h00000 && block_len <= `OAG_BLOCK_MAX_LEN &&
      ext_len <= `OAG_EXT_MAX_LEN |=> len_ok)
      else $error("legal lengths refused");

   // A low enable must hold every answer, even with a request pending
   a_freeze_hold: assert property (@(posedge clk) disable iff (srst)
      !ce |=>
      $stable(ans) && $stable(ans_valid) && $stable(len_ok) && $stable(bit_mask))
      else $error("state moved while enable low");
endmodule
`default_nettype wire

// File: verilog/oag_regs.svh
/*
 Constants for the operand address generator: mode codes, space codes,
 register selects, size and length limits.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef OAG_REGS_SVH
`define OAG_REGS_SVH
`define OAG_MODE_DIRECT 3'h0
`define OAG_MODE_TABLE 3'h1
`define OAG_MODE_SHORT 3'h2
`define OAG_MODE_COUNTER 3'h3
`define OAG_MODE_STACK 3'h4
`define OAG_MODE_PAIR 3'h5
`define OAG_SPACE_DATA 2'h0
`define OAG_SPACE_IO 2'h1
`define OAG_SPACE_PROG 2'h2
`define OAG_SEL_PRIMARY 2'h0
`define OAG_SEL_INDEX_ONE 2'h1
`define OAG_SEL_INDEX_TWO 2'h2
`define OAG_BLOCK_MAX_LEN 17'h10000
`define OAG_EXT_MAX_LEN 5'h10
`define OAG_SIGN_BIT 7
`endif

// File: verilog/oag_pkg.sv
/*
 Types of the operand address generator.
 Assumes the constants header is on the include path.
*/
`default_nettype none
`include "oag_regs.svh"
package oag_pkg;
   typedef enum logic [2:0]
   {
      OAG_DIRECT = 3'h0,
      OAG_TABLE = 3'h1,
      OAG_SHORT = 3'h2,
      OAG_COUNTER = 3'h3,
      OAG_STACK = 3'h4,
      OAG_PAIR = 3'h5
   } oag_mode_t;
   typedef enum logic [1:0]
   {
      OAG_SP_DATA = 2'h0,
      OAG_SP_IO = 2'h1,
      OAG_SP_PROG = 2'h2
   } oag_space_t;
   typedef struct packed
   {
      oag_mode_t mode;
      logic is_io;
      logic is_jump;
      logic is_ext;
      logic word_disp;
      logic word_size;
      logic [1:0] base_sel;
      logic [1:0] add_sel;
      logic [15:0] addr_field;
      logic [15:0] disp;
   } oag_req_t;
   typedef struct packed
   {
      logic [15:0] primary_pointer_pair;
      logic [15:0] index_register_one;
      logic [15:0] index_register_two;
      logic [15:0] sys_sp;
      logic [15:0] usr_sp;
      logic [15:0] next_pc;
      logic [15:0] template_pc;
      logic user_mode;
   } oag_regs_t;
   typedef struct packed
   {
      logic [15:0] addr;
      oag_space_t space;
      logic word_size;
      logic load_pc;
   } oag_ans_t;
endpackage
`default_nettype wire

// File: tb/oag_space_model.sv
/*
 Far-side model of the core's address spaces: counts the operand
 accesses that reach data memory, I/O and program memory.
 Assumes one-cycle answer pulses; counter loads are not accesses.
*/
`default_nettype none
module oag_space_model
   import oag_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ans_valid,
   input wire oag_ans_t ans,
   output logic [7:0] data_hits_ff,
   output logic [7:0] io_hits_ff,
   output logic [7:0] prog_hits_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   // Byte addressed, so every 16-bit address is a legal access
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         data_hits_ff <= 8'h00;
         io_hits_ff <= 8'h00;
         prog_hits_ff <= 8'h00;
      end
      else if (ans_valid && !ans.load_pc)
      begin
         data_hits_ff <= data_hits_ff + 8'(ans.space == OAG_SP_DATA);
         io_hits_ff <= io_hits_ff + 8'(ans.space == OAG_SP_IO);
         prog_hits_ff <= prog_hits_ff + 8'(ans.space == OAG_SP_PROG);
      end
   end
endmodule
`default_nettype wire

// File: tb/testbench.sv
/*
 Self-checking bench for the operand address generator.
 Assumes the package and constants header are compiled first.
*/
`default_nettype none
module testbench import oag_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic req_valid = 1'b0;
   oag_req_t req = '0;
   oag_regs_t regs = '0;
   logic [16:0] block_len = '0;
   logic [4:0] ext_len = '0;
   logic [2:0] bit_num = '0;
   logic [7:0] bcd_byte = '0;
   logic ans_valid, len_ok;
   oag_ans_t ans;
   logic [7:0] bit_mask, d_hits, i_hits, p_hits;
   logic [3:0] bcd_hi, bcd_lo;
   int num_errors = 0;
   int checked = 0;
   always #2 clk = ~clk;
   oag_addr_gen i_oag_addr_gen (.clk, .srst, .ce, .req_valid, .req, .regs, .block_len,
      .ext_len, .bit_num, .bcd_byte, .ans_valid, .ans, .len_ok, .bit_mask, .bcd_hi, .bcd_lo);
   oag_space_model i_oag_space_model (.clk, .srst, .ans_valid, .ans,
      .data_hits_ff(d_hits), .io_hits_ff(i_hits), .prog_hits_ff(p_hits));
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic setr(input oag_regs_t r);
      @(posedge clk) regs <= r;
   endtask
   // f is {io, jump, ext, word displacement, word size}; s is {add_sel, base_sel}
   task automatic go(input oag_mode_t m, input logic [4:0] f, input logic [3:0] s,
      input logic [15:0] af, input logic [15:0] d, input logic [15:0] ea,
      input oag_space_t sp, input logic lp);
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{m, f[4], f[3], f[2], f[1], f[0], s[1:0], s[3:2], af, d};
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      chk("ans_valid", ans_valid, 1);
      chk("addr", ans.addr, ea);
      chk("load_pc", ans.load_pc, lp);
      chk("word_size", ans.word_size, f[0]);
      if (!lp)
         chk("space", ans.space, sp);
   endtask
   task automatic t_direct();
      go(OAG_DIRECT, 5'h00, 4'h0, 16'h5e22, 16'h0, 16'h5e22, OAG_SP_DATA, 0);
      go(OAG_DIRECT, 5'h11, 4'h0, 16'h0034, 16'h0, 16'h0034, OAG_SP_IO, 0);
      go(OAG_DIRECT, 5'h08, 4'h0, 16'h1234, 16'h0, 16'h1234, OAG_SP_DATA, 1);
   endtask
   task automatic t_table();
      setr('{16'hffff, 16'h01fe, 16'h8000, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0});
      go(OAG_TABLE, 5'h0, 4'h1, 16'h231a, 16'h0, 16'h2518, OAG_SP_DATA, 0);
      go(OAG_TABLE, 5'h0, 4'h0, 16'h0002, 16'h0, 16'h0001, OAG_SP_DATA, 0);
      go(OAG_TABLE, 5'h0, 4'h2, 16'h8000, 16'h0, 16'h0000, OAG_SP_DATA, 0);
   endtask
   task automatic t_short();
      setr('{16'h0, 16'h203a, 16'h8000, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0});
      go(OAG_SHORT, 5'h0, 4'h1, 16'h0, 16'h12ff, 16'h2039, OAG_SP_DATA, 0);
      go(OAG_SHORT, 5'h0, 4'h2, 16'h0, 16'hab7f, 16'h807f, OAG_SP_DATA, 0);
   endtask
   task automatic t_counter();
      setr('{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0204, 16'h1000, 1'b0});
      go(OAG_COUNTER, 5'h00, 4'h0, 16'h0, 16'h0080, 16'h0184, OAG_SP_PROG, 0);
      go(OAG_COUNTER, 5'h02, 4'h0, 16'h0, 16'h8000, 16'h8204, OAG_SP_PROG, 0);
      go(OAG_COUNTER, 5'h04, 4'h0, 16'h0, 16'h0010, 16'h1010, OAG_SP_PROG, 0);
      go(OAG_COUNTER, 5'h08, 4'h0, 16'h0, 16'h00fe, 16'h0202, OAG_SP_PROG, 1);
   endtask
   task automatic t_stack();
      setr('{16'h0, 16'h0, 16'h0, 16'h8200, 16'h4000, 16'h0, 16'h0, 1'b0});
      go(OAG_STACK, 5'h0, 4'h0, 16'h0, 16'h0002, 16'h8202, OAG_SP_DATA, 0);
      setr('{16'h0, 16'h0, 16'h0, 16'h8200, 16'h4000, 16'h0, 16'h0, 1'b1});
      go(OAG_STACK, 5'h0, 4'h0, 16'h0, 16'hfffe, 16'h3ffe, OAG_SP_DATA, 0);
   endtask
   task automatic t_pair();
      setr('{16'h1502, 16'hfffe, 16'h0100, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0});
      go(OAG_PAIR, 5'h0, 4'h4, 16'h0, 16'h0, 16'h1500, OAG_SP_DATA, 0);
      go(OAG_PAIR, 5'h0, 4'h9, 16'h0, 16'h0, 16'h00fe, OAG_SP_DATA, 0);
   endtask
   task automatic t_freeze();
      @(posedge clk);
      ce <= 1'b0;
      req_valid <= 1'b1;
      req <= '{OAG_DIRECT, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 16'h0bad, 16'h0};
      bit_num <= 3'h2;
      repeat (2) @(posedge clk);
      #1;
      chk("frozen_valid", ans_valid, 0);
      chk("frozen_addr", ans.addr, 16'h00fe);
      chk("frozen_mask", bit_mask, 8'h01);
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      chk("thawed_valid", ans_valid, 1);
      chk("thawed_addr", ans.addr, 16'h0bad);
   endtask
   task automatic t_side();
      logic [16:0] bl [5] = '{17'h0, 17'h1, 17'h10000, 17'h10001, 17'h1};
      logic [4:0] el [5] = '{5'h0, 5'h0, 5'h10, 5'h0, 5'h11};
      logic ok [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk) bit_num <= 3'(i);
         bcd_byte <= 8'h97;
         @(posedge clk) #1;
         chk("bit_mask", bit_mask, 32'h1 << i);
      end
      chk("bcd_hi", bcd_hi, 4'h9);
      chk("bcd_lo", bcd_lo, 4'h7);
      for (int i = 0; i < 5; i++)
      begin
         @(posedge clk) block_len <= bl[i];
         ext_len <= el[i];
         @(posedge clk) #1;
         chk("len_ok", len_ok, ok[i]);
      end
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      t_direct();
      t_table();
      t_short();
      t_counter();
      t_stack();
      t_pair();
      t_freeze();
      t_side();
      chk("io_hits", i_hits, 1);
      chk("prog_hits", p_hits, 3);
      chk("data_hits", d_hits, 11);
      end_sim();
   end
   initial
   begin
      #20000;
      num_errors++;
      end_sim();
   end
endmodule
`default_nettype wire
